// [usb_bank_pkg.sv]
// constants, field layout and offsets of the interrupt, test and status register bank
package usb_bank_pkg;

	// ----------------------------------------
	// widths
	// ----------------------------------------
	localparam int IRQ_N          = 12;
	localparam int ADR_W          = 8;
	localparam int DAT_W          = 32;
	localparam int SEL_W          = 4;
	localparam int BYTE_W         = 8;
	localparam int PTR_W          = 7;
	localparam int ST_W           = 2;
	localparam int FRAME_W        = 11;
	localparam int QLVL_W         = 2;
	localparam int IN_EP_N        = 4;
	localparam int OUT_EP_N       = 3;
	localparam int IN_EP_NO_STATE = 2;
	localparam int SYNC_N         = 2;

	// ----------------------------------------
	// register offsets
	// ----------------------------------------
	localparam logic [ADR_W-1:0] OFF_IRQ_PENDING = 8'h0c;
	localparam logic [ADR_W-1:0] OFF_IRQ_ENABLE  = 8'h10;
	localparam logic [ADR_W-1:0] OFF_IRQ_CLEAR   = 8'h14;
	localparam logic [ADR_W-1:0] OFF_PAD_TEST    = 8'h1c;
	localparam logic [ADR_W-1:0] OFF_SCAN_FIFO   = 8'h20;
	localparam logic [ADR_W-1:0] OFF_FRAME       = 8'h24;
	localparam logic [ADR_W-1:0] OFF_IN_EP0      = 8'h28;
	localparam logic [ADR_W-1:0] OFF_IN_EP1      = 8'h2c;
	localparam logic [ADR_W-1:0] OFF_IN_EP2      = 8'h30;
	localparam logic [ADR_W-1:0] OFF_IN_EP3      = 8'h34;
	localparam logic [ADR_W-1:0] OFF_OUT_EP0     = 8'h38;
	localparam logic [ADR_W-1:0] OFF_OUT_EP1     = 8'h3c;
	localparam logic [ADR_W-1:0] OFF_OUT_EP2     = 8'h40;
	localparam logic [ADR_W-1:0] OFF_VERSION     = 8'h80;

	// ----------------------------------------
	// interrupt source positions
	// ----------------------------------------
	localparam int EV_SCAN_FLUSH      = 0;
	localparam int EV_FRAME_START     = 1;
	localparam int EV_SERIAL_RX       = 2;
	localparam int EV_SERIAL_TX_EMPTY = 3;
	localparam int EV_PID_ERROR       = 4;
	localparam int EV_SHORT_CHECK     = 5;
	localparam int EV_LONG_CHECK      = 6;
	localparam int EV_STUFF_ERROR     = 7;
	localparam int EV_EP1_IN_TOKEN    = 8;
	localparam int EV_BUS_RESET       = 9;
	localparam int EV_EP1_EMPTY_PKT   = 10;
	localparam int EV_EP2_EMPTY_PKT   = 11;

	// ----------------------------------------
	// field positions
	// ----------------------------------------
	localparam int PAD_EN_BIT        = 0;
	localparam int PAD_OE_BIT        = 1;
	localparam int PAD_PLUS_OUT_BIT  = 2;
	localparam int PAD_MINUS_OUT_BIT = 3;
	localparam int PAD_DIFF_IN_BIT   = 4;
	localparam int PAD_PLUS_IN_BIT   = 5;
	localparam int SQ_IN_EMPTY_BIT   = 0;
	localparam int SQ_IN_FULL_BIT    = 1;
	localparam int SQ_LVL_LSB        = 2;
	localparam int SQ_OUT_EMPTY_BIT  = 4;
	localparam int SQ_OUT_FULL_BIT   = 5;
	localparam int SQ_IN_RST_BIT     = 6;
	localparam int SQ_OUT_RST_BIT    = 7;
	localparam int EP_ST_LSB         = 0;
	localparam int EP_WR_LSB         = 2;
	localparam int EP_RD_LSB         = 9;
	localparam int EP_CNT_LSB        = 16;

	// version stamp reset value, arbitrary
	localparam logic [DAT_W-1:0] VERSION_RESET = 32'h00000001;

	typedef enum logic {BUS_IDLE, BUS_ACK} bus_state_e;

endpackage

// [irq_link_if.sv]
// carrier between the register bank and its interrupt core
`timescale 1ns/1ns
interface irq_link_if
	import usb_bank_pkg::*;
();
	logic [IRQ_N-1:0] set;
	logic [IRQ_N-1:0] clr;
	logic             mask_we;
	logic [IRQ_N-1:0] mask_wdata;
	logic [IRQ_N-1:0] pending;
	logic [IRQ_N-1:0] mask;
	logic             irq;

	modport bank (output set, clr, mask_we, mask_wdata, input pending, mask, irq);
	modport core (input set, clr, mask_we, mask_wdata, output pending, mask, irq);
endinterface

// [irq_core.sv]
// sticky pending bits, enable mask and level interrupt
`timescale 1ns/1ns
module irq_core
	import usb_bank_pkg::*;
(
	input  wire logic clock_i,
	input  wire logic resetn_i,
	irq_link_if.core  lnk
);

	logic [IRQ_N-1:0] pending_r;
	logic [IRQ_N-1:0] mask_r;

	// ----------------------------------------
	// pending bits: set wins over clear
	// ----------------------------------------
	always_ff @(posedge clock_i) begin
		if (!resetn_i) begin
			pending_r <= '0;
		end else begin
			pending_r <= lnk.set | (pending_r & ~lnk.clr);
		end
	end

	// ----------------------------------------
	// enable mask
	// ----------------------------------------
	always_ff @(posedge clock_i) begin
		if (!resetn_i) begin
			mask_r <= '0;
		end else if (lnk.mask_we) begin
			mask_r <= lnk.mask_wdata;
		end
	end

	assign lnk.pending = pending_r;
	assign lnk.mask    = mask_r;
	assign lnk.irq     = |(pending_r & mask_r);

endmodule

// [usb_bridge_irq_status_bank.sv]
// interrupt, pad test and status register bank with a classic wishbone slave
// Functional notes
// - a read-only status register shows the pending state of all twelve interrupt sources.
// - a read/write enable register holds one enable bit per source at the status bit positions.
// - writing one to a bit of the clear register clears that pending bit, zero does nothing, nothing stored.
// - hardware sets pending bits on scan flush, frame start, serial packet received and serial IN empty.
// - hardware also sets bits on pid, short and long check, stuffing errors, ep1 IN token, bus reset, empty OUT packets.
// - with pad test enabled the pad enable and plus/minus levels come from register fields.
// - in pad test mode the differential and plus receive levels read back as read-only fields.
// - empty and full flags of both scan queues and the OUT queue level read back, active high.
// - writing one to either scan queue reset field resets that queue, both fields read back.
// - the index of each received frame start packet is kept in the frame number register.
// - IN endpoints 0..3 show write and read pointers, endpoints 0, 1 and 3 also their state.
// - OUT endpoints 0..2 show state, write pointer and read pointer.
// - after a packet received event an OUT endpoint holds write pointer minus two bytes.
// - a read-only field gives the byte count of the last packet received on OUT endpoint 1.
`timescale 1ns/1ns
module usb_bridge_irq_status_bank
	import usb_bank_pkg::*;
(
	input  wire logic                              clock_i,
	input  wire logic                              resetn_i,
	input  wire logic                              wb_cyc_i,
	input  wire logic                              wb_stb_i,
	input  wire logic                              wb_we_i,
	input  wire logic [ADR_W-1:0]                  wb_adr_i,
	input  wire logic [SEL_W-1:0]                  wb_sel_i,
	input  wire logic [DAT_W-1:0]                  wb_dat_i,
	output wire logic [DAT_W-1:0]                  wb_dat_o,
	output wire logic                              wb_ack_o,
	output wire logic                              irq_o,
	input  wire logic [IRQ_N-1:0]                  irq_event_i,
	input  wire logic                              frame_valid_i,
	input  wire logic [FRAME_W-1:0]                frame_index_i,
	input  wire logic                              scan_in_empty_i,
	input  wire logic                              scan_in_full_i,
	input  wire logic                              scan_out_empty_i,
	input  wire logic                              scan_out_full_i,
	input  wire logic [QLVL_W-1:0]                 scan_rx_queue_level_i,
	output wire logic                              scan_in_reset_o,
	output wire logic                              scan_out_reset_o,
	input  wire logic [IN_EP_N-1:0][ST_W-1:0]      in_ep_state_i,
	input  wire logic [IN_EP_N-1:0][PTR_W-1:0]     in_ep_wr_ptr_i,
	input  wire logic [IN_EP_N-1:0][PTR_W-1:0]     in_ep_rd_ptr_i,
	input  wire logic [OUT_EP_N-1:0][ST_W-1:0]     out_ep_state_i,
	input  wire logic [OUT_EP_N-1:0][PTR_W-1:0]    out_ep_wr_ptr_i,
	input  wire logic [OUT_EP_N-1:0][PTR_W-1:0]    out_ep_rd_ptr_i,
	input  wire logic [PTR_W-1:0]                  ep1_rx_packet_bytes_i,
	input  wire logic                              norm_oe_i,
	input  wire logic                              norm_plus_i,
	input  wire logic                              norm_minus_i,
	input  wire logic                              pad_test_diff_in_i,
	input  wire logic                              pad_test_plus_in_i,
	output wire logic                              pad_oe_o,
	output wire logic                              pad_plus_o,
	output wire logic                              pad_minus_o
);

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	function automatic logic [DAT_W-1:0] lane_mask(input logic [SEL_W-1:0] sel);
		logic [DAT_W-1:0] m;
		m = '0;
		for (int b = 0; b < SEL_W; b++) begin
			m[b*BYTE_W +: BYTE_W] = {BYTE_W{sel[b]}};
		end
		return m;
	endfunction

	function automatic logic [DAT_W-1:0] lane_merge(
		input logic [DAT_W-1:0] old_v,
		input logic [DAT_W-1:0] new_v,
		input logic [SEL_W-1:0] sel
	);
		logic [DAT_W-1:0] m;
		m = lane_mask(sel);
		return (old_v & ~m) | (new_v & m);
	endfunction

	// ----------------------------------------
	// declarations
	// ----------------------------------------
	bus_state_e       bus_state_r;
	bus_state_e       bus_state_nxt;
	logic [DAT_W-1:0] rdata_r;
	logic [DAT_W-1:0] rdata_nxt;
	logic             commit;
	logic             wr_commit;
	logic             rd_commit;
	logic [DAT_W-1:0] pad_ctl_r;
	logic [DAT_W-1:0] pad_ctl_nxt;
	logic             scan_in_rst_r;
	logic             scan_out_rst_r;
	logic [DAT_W-1:0] scan_nxt;
	logic [FRAME_W-1:0] frame_r;
	logic [DAT_W-1:0] version_r;
	logic [SYNC_N-1:0] pin_meta_r;
	logic [SYNC_N-1:0] pin_sync_r;
	logic             pad_oe_r;
	logic             pad_plus_r;
	logic             pad_minus_r;
	logic [DAT_W-1:0] in_word [IN_EP_N];
	logic [DAT_W-1:0] out_word [OUT_EP_N];
	logic [DAT_W-1:0] pad_word;
	logic [DAT_W-1:0] scan_word;
	logic [IRQ_N-1:0] wr_clear;
	logic [IRQ_N-1:0] rd_clear;

	irq_link_if lnk ();

	// ----------------------------------------
	// interrupt core
	// ----------------------------------------
	irq_core u_irq (
		.clock_i  (clock_i),
		.resetn_i (resetn_i),
		.lnk      (lnk.core)
	);

	assign lnk.set        = irq_event_i;
	assign wr_clear       = (wr_commit && wb_adr_i == OFF_IRQ_CLEAR) ?
	                        (wb_dat_i[IRQ_N-1:0] & IRQ_N'(lane_mask(wb_sel_i))) : '0;
	// only bits that were shown to software are cleared by the read
	assign rd_clear       = (rd_commit && wb_adr_i == OFF_IRQ_PENDING) ? rdata_r[IRQ_N-1:0] : '0;
	assign lnk.clr        = wr_clear | rd_clear;
	assign lnk.mask_we    = wr_commit && wb_adr_i == OFF_IRQ_ENABLE;
	assign lnk.mask_wdata = IRQ_N'(lane_merge({{(DAT_W-IRQ_N){1'b0}}, lnk.mask}, wb_dat_i, wb_sel_i));
	assign irq_o          = lnk.irq;

	// ----------------------------------------
	// wishbone slave
	// ----------------------------------------
	always_comb begin
		bus_state_nxt = bus_state_r;
		case (bus_state_r)
			BUS_IDLE: begin
				if (wb_cyc_i && wb_stb_i) begin
					bus_state_nxt = BUS_ACK;
				end
			end
			BUS_ACK: begin
				bus_state_nxt = BUS_IDLE;
			end
			default: begin
				bus_state_nxt = BUS_IDLE;
			end
		endcase
	end

	always_ff @(posedge clock_i) begin
		if (!resetn_i) begin
			bus_state_r <= BUS_IDLE;
		end else begin
			bus_state_r <= bus_state_nxt;
		end
	end

	// effects take place at the edge where the master sees ack
	assign commit    = (bus_state_r == BUS_ACK) && wb_cyc_i && wb_stb_i;
	assign wr_commit = commit && wb_we_i;
	assign rd_commit = commit && !wb_we_i;
	assign wb_ack_o  = (bus_state_r == BUS_ACK);
	assign wb_dat_o  = rdata_r;

	always_ff @(posedge clock_i) begin
		if (!resetn_i) begin
			rdata_r <= '0;
		end else if (bus_state_r == BUS_IDLE && wb_cyc_i && wb_stb_i) begin
			rdata_r <= wb_we_i ? '0 : rdata_nxt;
		end
	end

	// ----------------------------------------
	// read mux
	// ----------------------------------------
	always_comb begin
		rdata_nxt = '0;
		case (wb_adr_i)
			OFF_IRQ_PENDING: begin
				rdata_nxt[IRQ_N-1:0] = lnk.pending;
			end
			OFF_IRQ_ENABLE: begin
				rdata_nxt[IRQ_N-1:0] = lnk.mask;
			end
			OFF_PAD_TEST: begin
				rdata_nxt = pad_word;
			end
			OFF_SCAN_FIFO: begin
				rdata_nxt = scan_word;
			end
			OFF_FRAME: begin
				rdata_nxt[FRAME_W-1:0] = frame_r;
			end
			OFF_IN_EP0: begin
				rdata_nxt = in_word[0];
			end
			OFF_IN_EP1: begin
				rdata_nxt = in_word[1];
			end
			OFF_IN_EP2: begin
				rdata_nxt = in_word[2];
			end
			OFF_IN_EP3: begin
				rdata_nxt = in_word[3];
			end
			OFF_OUT_EP0: begin
				rdata_nxt = out_word[0];
			end
			OFF_OUT_EP1: begin
				rdata_nxt = out_word[1];
			end
			OFF_OUT_EP2: begin
				rdata_nxt = out_word[2];
			end
			OFF_VERSION: begin
				rdata_nxt = version_r;
			end
			default: begin
				rdata_nxt = '0;
			end
		endcase
	end

	// ----------------------------------------
	// pad test control
	// ----------------------------------------
	always_comb begin
		pad_ctl_nxt = '0;
		pad_ctl_nxt[PAD_MINUS_OUT_BIT:PAD_EN_BIT] = wb_dat_i[PAD_MINUS_OUT_BIT:PAD_EN_BIT];
		pad_ctl_nxt = lane_merge(pad_ctl_r, pad_ctl_nxt, wb_sel_i);
	end

	always_ff @(posedge clock_i) begin
		if (!resetn_i) begin
			pad_ctl_r <= '0;
		end else if (wr_commit && wb_adr_i == OFF_PAD_TEST) begin
			pad_ctl_r <= pad_ctl_nxt;
		end
	end

	// receive pins come from outside the clock domain
	always_ff @(posedge clock_i) begin
		if (!resetn_i) begin
			pin_meta_r <= '0;
			pin_sync_r <= '0;
		end else begin
			pin_meta_r <= {pad_test_plus_in_i, pad_test_diff_in_i};
			pin_sync_r <= pin_meta_r;
		end
	end

	always_comb begin
		pad_word = pad_ctl_r;
		if (pad_ctl_r[PAD_EN_BIT]) begin
			pad_word[PAD_DIFF_IN_BIT] = pin_sync_r[0];
			pad_word[PAD_PLUS_IN_BIT] = pin_sync_r[1];
		end
	end

	always_ff @(posedge clock_i) begin
		if (!resetn_i) begin
			pad_oe_r    <= 1'b0;
			pad_plus_r  <= 1'b0;
			pad_minus_r <= 1'b0;
		end else if (pad_ctl_r[PAD_EN_BIT]) begin
			pad_oe_r    <= pad_ctl_r[PAD_OE_BIT];
			pad_plus_r  <= pad_ctl_r[PAD_PLUS_OUT_BIT];
			pad_minus_r <= pad_ctl_r[PAD_MINUS_OUT_BIT];
		end else begin
			pad_oe_r    <= norm_oe_i;
			pad_plus_r  <= norm_plus_i;
			pad_minus_r <= norm_minus_i;
		end
	end

	assign pad_oe_o    = pad_oe_r;
	assign pad_plus_o  = pad_plus_r;
	assign pad_minus_o = pad_minus_r;

	// ----------------------------------------
	// scan queue status and resets
	// ----------------------------------------
	assign scan_nxt = lane_merge(scan_word, wb_dat_i, wb_sel_i);

	always_ff @(posedge clock_i) begin
		if (!resetn_i) begin
			scan_in_rst_r  <= 1'b0;
			scan_out_rst_r <= 1'b0;
		end else if (wr_commit && wb_adr_i == OFF_SCAN_FIFO) begin
			scan_in_rst_r  <= scan_nxt[SQ_IN_RST_BIT];
			scan_out_rst_r <= scan_nxt[SQ_OUT_RST_BIT];
		end
	end

	assign scan_in_reset_o  = scan_in_rst_r;
	assign scan_out_reset_o = scan_out_rst_r;

	always_comb begin
		scan_word = '0;
		scan_word[SQ_IN_EMPTY_BIT]              = scan_in_empty_i;
		scan_word[SQ_IN_FULL_BIT]               = scan_in_full_i;
		scan_word[SQ_LVL_LSB +: QLVL_W]         = scan_rx_queue_level_i;
		scan_word[SQ_OUT_EMPTY_BIT]             = scan_out_empty_i;
		scan_word[SQ_OUT_FULL_BIT]              = scan_out_full_i;
		scan_word[SQ_IN_RST_BIT]                = scan_in_rst_r;
		scan_word[SQ_OUT_RST_BIT]               = scan_out_rst_r;
	end

	// ----------------------------------------
	// frame number and version stamp
	// ----------------------------------------
	always_ff @(posedge clock_i) begin
		if (!resetn_i) begin
			frame_r <= '0;
		end else if (frame_valid_i) begin
			frame_r <= frame_index_i;
		end
	end

	always_ff @(posedge clock_i) begin
		if (!resetn_i) begin
			version_r <= VERSION_RESET;
		end else if (wr_commit && wb_adr_i == OFF_VERSION) begin
			version_r <= lane_merge(version_r, wb_dat_i, wb_sel_i);
		end
	end

	// ----------------------------------------
	// endpoint status words
	// ----------------------------------------
	for (genvar g = 0; g < IN_EP_N; g++) begin : g_in_ep
		always_comb begin
			in_word[g] = '0;
			in_word[g][EP_WR_LSB +: PTR_W] = in_ep_wr_ptr_i[g];
			in_word[g][EP_RD_LSB +: PTR_W] = in_ep_rd_ptr_i[g];
			if (g != IN_EP_NO_STATE) begin
				in_word[g][EP_ST_LSB +: ST_W] = in_ep_state_i[g];
			end
		end
	end

	for (genvar g = 0; g < OUT_EP_N; g++) begin : g_out_ep
		always_comb begin
			out_word[g] = '0;
			out_word[g][EP_ST_LSB +: ST_W]  = out_ep_state_i[g];
			// software takes the byte count as write pointer minus two
			out_word[g][EP_WR_LSB +: PTR_W] = out_ep_wr_ptr_i[g];
			out_word[g][EP_RD_LSB +: PTR_W] = out_ep_rd_ptr_i[g];
			if (g == 1) begin
				out_word[g][EP_CNT_LSB +: PTR_W] = ep1_rx_packet_bytes_i;
			end
		end
	end

endmodule

// [usb_bank_sva.sv]
// port checks of the register bank
`timescale 1ns/1ns
module usb_bank_sva
	import usb_bank_pkg::*;
(
	input wire logic             clock_i,
	input wire logic             resetn_i,
	input wire logic             wb_cyc_i,
	input wire logic             wb_stb_i,
	input wire logic             wb_we_i,
	input wire logic [ADR_W-1:0] wb_adr_i,
	input wire logic [SEL_W-1:0] wb_sel_i,
	input wire logic [DAT_W-1:0] wb_dat_i,
	input wire logic [DAT_W-1:0] wb_dat_o,
	input wire logic             wb_ack_o,
	input wire logic             irq_o,
	input wire logic [IRQ_N-1:0] irq_event_i,
	input wire logic             scan_in_reset_o,
	input wire logic             scan_out_reset_o,
	input wire logic             norm_oe_i,
	input wire logic             norm_plus_i,
	input wire logic             norm_minus_i,
	input wire logic             pad_oe_o,
	input wire logic             pad_plus_o,
	input wire logic             pad_minus_o
);
	logic [3:0]       pad_r;
	logic [IRQ_N-1:0] en_r;
	logic             wr_ack;
	logic             rd_ack;
	logic             clr_acc;
	assign wr_ack  = wb_ack_o && wb_cyc_i && wb_stb_i && wb_we_i;
	assign rd_ack  = wb_ack_o && wb_cyc_i && wb_stb_i && !wb_we_i;
	assign clr_acc = (wr_ack && (wb_adr_i == OFF_IRQ_CLEAR || wb_adr_i == OFF_IRQ_ENABLE))
		|| (rd_ack && wb_adr_i == OFF_IRQ_PENDING);
	// ----------------------------------------
	// shadows of software-written fields
	// ----------------------------------------
	always_ff @(posedge clock_i) begin
		if (!resetn_i) begin
			pad_r <= '0;
		end else if (wr_ack && wb_adr_i == OFF_PAD_TEST && wb_sel_i[0]) begin
			pad_r <= wb_dat_i[3:0];
		end
	end
	always_ff @(posedge clock_i) begin
		if (!resetn_i) begin
			en_r <= '0;
		end else if (wr_ack && wb_adr_i == OFF_IRQ_ENABLE) begin
			en_r <= {wb_sel_i[1] ? wb_dat_i[11:8] : en_r[11:8], wb_sel_i[0] ? wb_dat_i[7:0] : en_r[7:0]};
		end
	end
	// ----------------------------------------
	// properties
	// ----------------------------------------
	default clocking cb @(posedge clock_i);
	endclocking
	default disable iff (!resetn_i);
	sequence s_req;
		wb_cyc_i && wb_stb_i && !wb_ack_o;
	endsequence
	sequence s_ack_pulse;
		wb_ack_o ##1 !wb_ack_o;
	endsequence
	property p_ack_pulse;
		s_req |=> s_ack_pulse;
	endproperty
	a_ack_pulse: assert property (p_ack_pulse) else $error("request not answered by a one-cycle ack");
	property p_status_upper;
		rd_ack && wb_adr_i == OFF_IRQ_PENDING |-> wb_dat_o[31:12] == 20'h0;
	endproperty
	a_status_upper: assert property (p_status_upper) else $error("status upper bits not zero");
	property p_clear_reads_zero;
		rd_ack && wb_adr_i == OFF_IRQ_CLEAR |-> wb_dat_o == 32'h0;
	endproperty
	a_clear_reads_zero: assert property (p_clear_reads_zero) else $error("clear register read not zero");
	property p_enable_read;
		rd_ack && wb_adr_i == OFF_IRQ_ENABLE |-> wb_dat_o == {20'h0, en_r};
	endproperty
	a_enable_read: assert property (p_enable_read) else $error("enable register read differs");
	property p_event_irq;
		(|(irq_event_i & en_r)) && !wr_ack |=> irq_o;
	endproperty
	a_event_irq: assert property (p_event_irq) else $error("enabled event did not raise irq");
	property p_irq_fall;
		$fell(irq_o) |-> $past(clr_acc);
	endproperty
	a_irq_fall: assert property (p_irq_fall) else $error("irq fell without a clearing access");
	property p_scan_reset;
		wr_ack && wb_adr_i == OFF_SCAN_FIFO && wb_sel_i[0] |=> {scan_out_reset_o, scan_in_reset_o} == $past(wb_dat_i[7:6]);
	endproperty
	a_scan_reset: assert property (p_scan_reset) else $error("queue reset outputs differ");
	property p_pad_select;
		$past(resetn_i) |-> {pad_minus_o, pad_plus_o, pad_oe_o}
			== $past(pad_r[0] ? pad_r[3:1] : {norm_minus_i, norm_plus_i, norm_oe_i});
	endproperty
	a_pad_select: assert property (p_pad_select) else $error("pad drive source wrong");
endmodule

bind usb_bridge_irq_status_bank usb_bank_sva usb_bank_sva_inst (.*);

// [far_side_model.sv]
// far side model of the register bank
`timescale 1ns/1ns
package far_side_pkg;
	import usb_bank_pkg::*;
	typedef struct packed {
		logic [IRQ_N-1:0]               ev;
		logic                           fvalid;
		logic [FRAME_W-1:0]             fidx;
		logic [3:0]                     qflags;
		logic [QLVL_W-1:0]              qlvl;
		logic [IN_EP_N-1:0][ST_W-1:0]   in_st;
		logic [IN_EP_N-1:0][PTR_W-1:0]  in_wr;
		logic [IN_EP_N-1:0][PTR_W-1:0]  in_rd;
		logic [OUT_EP_N-1:0][ST_W-1:0]  out_st;
		logic [OUT_EP_N-1:0][PTR_W-1:0] out_wr;
		logic [OUT_EP_N-1:0][PTR_W-1:0] out_rd;
		logic [PTR_W-1:0]               ep1_bytes;
		logic [2:0]                     norm;
		logic [1:0]                     pad_in;
	} far_side_s;
endpackage

module far_side_model
	import usb_bank_pkg::*, far_side_pkg::*;
(
	input  wire logic clock_i,
	output far_side_s fs_o
);
	initial begin
		fs_o = '0;
		fs_o.qflags = 4'b0110;
		fs_o.qlvl = 2'h2;
		for (int i = 0; i < IN_EP_N; i++) begin
			fs_o.in_st[i] = ST_W'(i + 1);
			fs_o.in_wr[i] = PTR_W'(17 * i + 5);
			fs_o.in_rd[i] = PTR_W'(9 * i + 3);
		end
		for (int i = 0; i < OUT_EP_N; i++) begin
			fs_o.out_st[i] = ST_W'(3 - i);
			fs_o.out_wr[i] = PTR_W'(21 * i + 2);
			fs_o.out_rd[i] = PTR_W'(i + 1);
		end
	end
	// pad drive counts up by one each cycle
	always @(posedge clock_i) begin
		fs_o.norm <= fs_o.norm + 3'h1;
	end
	task automatic fire(input logic [IRQ_N-1:0] m);
		@(posedge clock_i);
		fs_o.ev <= m;
		@(posedge clock_i);
		fs_o.ev <= '0;
	endtask
	// index shows its inverse after the strobe
	task automatic frame(input logic [FRAME_W-1:0] idx);
		@(posedge clock_i);
		fs_o.fvalid <= 1'b1;
		fs_o.fidx <= idx;
		fs_o.ev[EV_FRAME_START] <= 1'b1;
		@(posedge clock_i);
		fs_o.fvalid <= 1'b0;
		fs_o.fidx <= ~idx;
		fs_o.ev <= '0;
	endtask
	task automatic out_packet(input int ep, input logic [PTR_W-1:0] n);
		@(posedge clock_i);
		fs_o.out_wr[ep] <= n + 7'h02;
		fs_o.ep1_bytes <= (ep == 1) ? n : fs_o.ep1_bytes;
		fs_o.ev[EV_SERIAL_RX] <= 1'b1;
		@(posedge clock_i);
		fs_o.ev <= '0;
	endtask
	task automatic pads(input logic [1:0] v);
		@(posedge clock_i);
		fs_o.pad_in <= v;
	endtask
endmodule

// [usb_bridge_irq_status_bank_tb.sv]
// testbench of the register bank
`timescale 1ns/1ns
module usb_bridge_irq_status_bank_tb
	import usb_bank_pkg::*, far_side_pkg::*;
();
	logic             clock_i  = 1'b0;
	logic             resetn_i = 1'b0;
	logic             wb_cyc   = 1'b0;
	logic             wb_stb   = 1'b0;
	logic             wb_we    = 1'b0;
	logic [ADR_W-1:0] wb_adr   = '0;
	logic [SEL_W-1:0] wb_sel   = '0;
	logic [DAT_W-1:0] wb_dat   = '0;
	logic [DAT_W-1:0] wb_dat_o;
	logic             wb_ack_o;
	logic             irq_o;
	logic             scan_in_reset_o;
	logic             scan_out_reset_o;
	logic             pad_oe_o;
	logic             pad_plus_o;
	logic             pad_minus_o;
	far_side_s        fs;
	int               err_count    = 0;
	int               total_checks = 0;

	always #2 clock_i = ~clock_i;

	far_side_model far_side_model_inst (.clock_i(clock_i), .fs_o(fs));
	usb_bridge_irq_status_bank usb_bridge_irq_status_bank_inst (
		.clock_i, .resetn_i, .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we), .wb_adr_i(wb_adr),
		.wb_sel_i(wb_sel), .wb_dat_i(wb_dat), .wb_dat_o, .wb_ack_o, .irq_o, .irq_event_i(fs.ev),
		.frame_valid_i(fs.fvalid), .frame_index_i(fs.fidx), .scan_in_empty_i(fs.qflags[0]),
		.scan_in_full_i(fs.qflags[1]), .scan_out_empty_i(fs.qflags[2]), .scan_out_full_i(fs.qflags[3]),
		.scan_rx_queue_level_i(fs.qlvl), .scan_in_reset_o, .scan_out_reset_o, .in_ep_state_i(fs.in_st),
		.in_ep_wr_ptr_i(fs.in_wr), .in_ep_rd_ptr_i(fs.in_rd), .out_ep_state_i(fs.out_st),
		.out_ep_wr_ptr_i(fs.out_wr), .out_ep_rd_ptr_i(fs.out_rd), .ep1_rx_packet_bytes_i(fs.ep1_bytes),
		.norm_oe_i(fs.norm[0]), .norm_plus_i(fs.norm[1]), .norm_minus_i(fs.norm[2]),
		.pad_test_diff_in_i(fs.pad_in[0]), .pad_test_plus_in_i(fs.pad_in[1]), .pad_oe_o, .pad_plus_o, .pad_minus_o
	);

	// ----------------------------------------
	// tasks
	// ----------------------------------------
	task automatic stop_test();
		$display("checks %0d mismatches %0d", total_checks, err_count);
		if (err_count == 0 && total_checks > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	task automatic check(input string what, input logic [DAT_W-1:0] seen, input logic [DAT_W-1:0] exp);
		total_checks++;
		if (seen !== exp) begin
			err_count++;
			$display("MISMATCH %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic bus(input logic we, input logic [ADR_W-1:0] adr, input logic [DAT_W-1:0] wd,
		input logic [SEL_W-1:0] sel, output logic [DAT_W-1:0] rd);
		@(posedge clock_i);
		{wb_cyc, wb_stb, wb_we, wb_adr, wb_dat, wb_sel} <= {1'b1, 1'b1, we, adr, wd, sel};
		@(posedge clock_i);
		while (wb_ack_o !== 1'b1) begin
			@(posedge clock_i);
		end
		rd = wb_dat_o;
		{wb_cyc, wb_stb, wb_we} <= 3'b000;
	endtask
	task automatic wr(input logic [ADR_W-1:0] adr, input logic [DAT_W-1:0] d, input logic [SEL_W-1:0] sel);
		logic [DAT_W-1:0] unused;
		bus(1'b1, adr, d, sel, unused);
	endtask
	task automatic rd_chk(input string what, input logic [ADR_W-1:0] adr, input logic [DAT_W-1:0] exp);
		logic [DAT_W-1:0] d;
		bus(1'b0, adr, '0, 4'hf, d);
		check(what, d, exp);
	endtask

	// watchdog
	initial begin
		repeat (20000) @(posedge clock_i);
		err_count++;
		stop_test();
	end

	// ----------------------------------------
	// tests
	// ----------------------------------------
	initial begin
		logic [DAT_W-1:0] d;
		repeat (6) @(posedge clock_i);
		resetn_i <= 1'b1;
		rd_chk("pending", OFF_IRQ_PENDING, 32'h0);
		rd_chk("enable", OFF_IRQ_ENABLE, 32'h0);
		rd_chk("version", OFF_VERSION, VERSION_RESET);
		rd_chk("unmapped", 8'h7c, 32'h0);
		wr(OFF_IRQ_ENABLE, 32'hffffffff, 4'hf);
		rd_chk("enable", OFF_IRQ_ENABLE, 32'h00000fff);
		wr(OFF_IRQ_ENABLE, 32'h0, 4'h2);
		rd_chk("enable", OFF_IRQ_ENABLE, 32'h000000ff);
		wr(OFF_IRQ_ENABLE, 32'hfff, 4'hf);
		for (int i = 0; i < IRQ_N; i++) begin
			far_side_model_inst.fire(12'h1 << i);
			@(negedge clock_i);
			check("irq", {31'h0, irq_o}, 32'h1);
			rd_chk("pending", OFF_IRQ_PENDING, 32'h1 << i);
			@(negedge clock_i);
			check("irq", {31'h0, irq_o}, 32'h0);
		end
		wr(OFF_IRQ_ENABLE, 32'h0, 4'hf);
		far_side_model_inst.fire(12'h0c0);
		@(negedge clock_i);
		check("irq masked", {31'h0, irq_o}, 32'h0);
		wr(OFF_IRQ_CLEAR, 32'h0000f040, 4'hf);
		rd_chk("clear", OFF_IRQ_CLEAR, 32'h0);
		wr(OFF_IRQ_ENABLE, 32'h080, 4'hf);
		@(negedge clock_i);
		check("irq", {31'h0, irq_o}, 32'h1);
		rd_chk("pending", OFF_IRQ_PENDING, 32'h080);
		far_side_model_inst.out_packet(1, 7'h05);
		rd_chk("pending", OFF_IRQ_PENDING, 32'h1 << EV_SERIAL_RX);
		far_side_model_inst.frame(11'h5a3);
		rd_chk("frame", OFF_FRAME, 32'h5a3);
		wr(OFF_FRAME, 32'hffffffff, 4'hf);
		rd_chk("frame", OFF_FRAME, 32'h5a3);
		for (int i = 0; i < IN_EP_N; i++) begin
			rd_chk("in ep", OFF_IN_EP0 + 8'(4 * i),
				{16'h0, fs.in_rd[i], fs.in_wr[i], (i == IN_EP_NO_STATE) ? 2'h0 : fs.in_st[i]});
		end
		for (int i = 0; i < OUT_EP_N; i++) begin
			rd_chk("out ep", OFF_OUT_EP0 + 8'(4 * i),
				{9'h0, (i == 1) ? fs.ep1_bytes : 7'h0, fs.out_rd[i], fs.out_wr[i], fs.out_st[i]});
		end
		bus(1'b0, OFF_OUT_EP1, '0, 4'hf, d);
		check("ep1 available", {25'h0, d[8:2] - 7'h02}, 32'h5);
		wr(OFF_SCAN_FIFO, 32'hc0, 4'h1);
		@(negedge clock_i);
		check("queue resets", {30'h0, scan_out_reset_o, scan_in_reset_o}, 32'h3);
		rd_chk("queue", OFF_SCAN_FIFO, {24'h0, 2'h3, fs.qflags[3:2], fs.qlvl, fs.qflags[1:0]});
		wr(OFF_SCAN_FIFO, 32'h40, 4'h1);
		@(negedge clock_i);
		check("queue resets", {30'h0, scan_out_reset_o, scan_in_reset_o}, 32'h1);
		far_side_model_inst.pads(2'b11);
		wr(OFF_PAD_TEST, 32'h0b, 4'h1);
		repeat (3) @(negedge clock_i);
		check("pads", {29'h0, pad_minus_o, pad_plus_o, pad_oe_o}, 32'h5);
		rd_chk("pad test", OFF_PAD_TEST, 32'h3b);
		wr(OFF_PAD_TEST, 32'h0, 4'h1);
		rd_chk("pad test", OFF_PAD_TEST, 32'h0);
		wr(OFF_VERSION, 32'h12345678, 4'hf);
		rd_chk("version", OFF_VERSION, 32'h12345678);
		stop_test();
	end
endmodule
